// >>> logic/feq_params.svh
// Purpose: Constants of the channel B equalizer coefficient bank.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes:   Included by the package and by every design file that needs a figure.
//
// Overview of operation
// R1 - Fourth tap holds a 12-bit signed coefficient in bits 11:0.
// R2 - Centre tap holds an 18-bit signed coefficient in bits 17:0 of 24.
// R3 - Sixth tap holds a 12-bit signed coefficient in bits 11:0.
// R4 - Seventh tap holds a 12-bit signed coefficient in bits 11:0.
// R5 - Eighth tap holds a 12-bit signed coefficient in bits 11:0.
// R6 - Ninth tap holds a 12-bit signed coefficient in bits 11:0.
// R7 - Readback shows the coefficient MSB as zero; the filter keeps the written value.
// R8 - First three taps sit at the three even indices below the fourth.
// R9 - Every coefficient register, reserved bits included, resets to zero.
`ifndef FEQ_PARAMS_SVH
`define FEQ_PARAMS_SVH

// Register indices of the nine taps, in tap order.
`define FEQ_IDX_TAP0       12'h448
`define FEQ_IDX_TAP1       12'h44A
`define FEQ_IDX_TAP2       12'h44C
`define FEQ_IDX_TAP3       12'h44E
`define FEQ_IDX_CENTER     12'h450
`define FEQ_IDX_TAP5       12'h453
`define FEQ_IDX_TAP6       12'h455
`define FEQ_IDX_TAP7       12'h457
`define FEQ_IDX_TAP8       12'h459

// Register and field geometry.
`define FEQ_NUM_TAPS       9
`define FEQ_CENTER_TAP     4
`define FEQ_OUTER_REG_W    16
`define FEQ_OUTER_FIELD_W  12
`define FEQ_CENTER_REG_W   24
`define FEQ_CENTER_FIELD_W 18
`define FEQ_INDEX_W        12

// Reset value of every register and of the read data bus.
`define FEQ_RESET_VAL      32'h0000_0000

`endif

// >>> logic/feq_pkg.sv
// Purpose: Types shared by the coefficient bank modules.
// Assumes: Figures come from feq_params.svh.
// Notes:   Nothing here is imported; users write feq_pkg::name.
`include "feq_params.svh"

package feq_pkg;

    // Coefficients as the filter datapath sees them.
    typedef logic signed [`FEQ_OUTER_FIELD_W-1:0]  feq_outer_coef_t;
    typedef logic signed [`FEQ_CENTER_FIELD_W-1:0] feq_center_coef_t;

    // One word on the register side, and its byte strobes.
    typedef logic [31:0]                           feq_word_t;
    typedef logic [3:0]                            feq_strb_t;
    typedef logic [`FEQ_INDEX_W-1:0]               feq_index_t;

endpackage : feq_pkg

// >>> logic/feq_reg_if.sv
// Purpose: Carries decoded register accesses from the bus slave to the bank.
// Assumes: One clock; all signals change right after a rising edge.
// Notes:   wr_stb is a one-cycle pulse; the rest are levels.
interface feq_reg_if;

    logic                wr_stb;
    feq_pkg::feq_strb_t  wr_strb;
    feq_pkg::feq_word_t  wr_data;
    feq_pkg::feq_index_t index;
    logic                hit;
    feq_pkg::feq_word_t  rd_data;

    // The bus side names the register; the bank answers with hit and data.
    modport bus
    (
        output wr_stb,
        output wr_strb,
        output wr_data,
        output index,
        input  hit,
        input  rd_data
    );

    modport bank
    (
        input  wr_stb,
        input  wr_strb,
        input  wr_data,
        input  index,
        output hit,
        output rd_data
    );

endinterface : feq_reg_if

// >>> logic/feq_coef_reg.sv
// Purpose: One coefficient register with byte-lane writes and a masked readback.
// Assumes: REG_W is a multiple of eight and at most 32.
// Notes:   Reserved bits above the field are stored and read back as written.
`include "feq_params.svh"

module feq_coef_reg
#(
    parameter int REG_W   = `FEQ_OUTER_REG_W,
    parameter int FIELD_W = `FEQ_OUTER_FIELD_W
)
(
    // Clock and reset.
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    // Write port.
    input  wire logic               we_i,
    input  wire feq_pkg::feq_strb_t strb_i,
    input  wire feq_pkg::feq_word_t wdata_i,
    // Stored value and readback.
    output logic [REG_W-1:0]        value_o,
    output feq_pkg::feq_word_t      rd_o
);

    localparam logic [REG_W-1:0] MSB_MASK = REG_W'(1) << (FIELD_W - 1);

    logic [REG_W-1:0] reg_ff;

    // Only the lanes that exist in this register are written; upper strobes are dropped.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_ff <= REG_W'(`FEQ_RESET_VAL); // see R9
        else if (we_i)
        begin
            for (int b = 0; b < REG_W / 8; b++)
            begin
                if (strb_i[b])
                    reg_ff[b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end

    // The filter sees the full written value; software sees the MSB cleared.
    assign value_o = reg_ff;
    assign rd_o    = 32'(reg_ff & ~MSB_MASK); // see R7

endmodule : feq_coef_reg

// >>> logic/feq_apb_slave.sv
// Purpose: APB slave front end for the coefficient bank.
// Assumes: The master holds the request stable through the access phase.
// Notes:   Every transfer takes exactly one access cycle; pready rises then.
`include "feq_params.svh"

module feq_apb_slave
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset.
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    // APB requester side.
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire feq_pkg::feq_word_t pwdata_i,
    input  wire feq_pkg::feq_strb_t pstrb_i,
    output logic                    pready_o,
    output feq_pkg::feq_word_t      prdata_o,
    output logic                    pslverr_o,
    // Decoded access toward the bank.
    feq_reg_if.bus                  reg_if
);

    logic               pready_ff;
    logic               pslverr_ff;
    feq_pkg::feq_word_t prdata_ff;
    logic               setup;
    logic               valid;

    // A misaligned byte address matches no register; index bits above the decode width must be zero,
    // or high addresses would alias onto the taps.
    assign setup  = psel_i && !penable_i;
    assign valid  = reg_if.hit && (paddr_i[1:0] == 2'b00)
                    && (paddr_i[ADDR_W-1:2] == (ADDR_W-2)'(reg_if.index));

    assign reg_if.index   = feq_pkg::feq_index_t'(paddr_i[ADDR_W-1:2]);
    assign reg_if.wr_strb = pstrb_i;
    assign reg_if.wr_data = pwdata_i;
    // The write lands on the single edge where the master samples pready high.
    assign reg_if.wr_stb  = psel_i && penable_i && pready_ff && pwrite_i && valid;

    // Answer one cycle after setup, so no extra wait state is ever inserted.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pready_ff <= 1'b0;
        else
            pready_ff <= setup;
    end

    // Unmapped or misaligned addresses are refused with an error response.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pslverr_ff <= 1'b0;
        else
            pslverr_ff <= setup && !valid;
    end

    // Read data is captured in setup and held until the next setup.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prdata_ff <= `FEQ_RESET_VAL;
        else if (setup)
            prdata_ff <= (!pwrite_i && valid) ? reg_if.rd_data : `FEQ_RESET_VAL;
    end

    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign prdata_o  = prdata_ff;

endmodule : feq_apb_slave

// >>> logic/feq_coef_bank.sv
// Purpose: Coefficient bank of the channel B nine-tap equalizer filter.
// Assumes: Single 20 MHz clock; APB reaches the registers at four times their index.
// Notes:   Tap outputs come straight from the register flops and feed the filter.
`include "feq_params.svh"

module feq_coef_bank
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset.
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    // APB slave port.
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [ADDR_W-1:0]        paddr_i,
    input  wire feq_pkg::feq_word_t       pwdata_i,
    input  wire feq_pkg::feq_strb_t       pstrb_i,
    output logic                          pready_o,
    output feq_pkg::feq_word_t            prdata_o,
    output logic                          pslverr_o,
    // Coefficients toward the equalizer filter datapath.
    output feq_pkg::feq_outer_coef_t      chan_b_tap0_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap1_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap2_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap3_value_o,
    output feq_pkg::feq_center_coef_t     chan_b_center_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap5_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap6_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap7_value_o,
    output feq_pkg::feq_outer_coef_t      chan_b_tap8_value_o
);

    localparam int NTAP = `FEQ_NUM_TAPS;

    feq_reg_if reg_if ();

    logic [NTAP-1:0]              sel_w;
    logic [31:0]                  value_w [NTAP];
    feq_pkg::feq_word_t           rd_w    [NTAP];
    feq_pkg::feq_word_t           rd_mux;

    // Register index of each tap; the odd indices above the centre follow its wider word.
    function automatic feq_pkg::feq_index_t tap_index(input int t);
        case (t)
            0:       return `FEQ_IDX_TAP0;   // see R8
            1:       return `FEQ_IDX_TAP1;   // see R8
            2:       return `FEQ_IDX_TAP2;   // see R8
            3:       return `FEQ_IDX_TAP3;   // see R1
            4:       return `FEQ_IDX_CENTER; // see R2
            5:       return `FEQ_IDX_TAP5;   // see R3
            6:       return `FEQ_IDX_TAP6;   // see R4
            7:       return `FEQ_IDX_TAP7;   // see R5
            8:       return `FEQ_IDX_TAP8;   // see R6
            default: return '0;
        endcase
    endfunction : tap_index

    // One-hot select of the tap addressed by an index; zero when unmapped.
    function automatic logic [NTAP-1:0] decode(input feq_pkg::feq_index_t idx);
        logic [NTAP-1:0] sel;
        sel = '0;
        for (int t = 0; t < NTAP; t++)
            sel[t] = (idx == tap_index(t));
        return sel;
    endfunction : decode

    // Bus front end; it alone drives the APB answer.
    feq_apb_slave
    #(
        .ADDR_W    (ADDR_W)
    )
    u_apb
    (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .pstrb_i   (pstrb_i),
        .pready_o  (pready_o),
        .prdata_o  (prdata_o),
        .pslverr_o (pslverr_o),
        .reg_if    (reg_if.bus)
    );

    assign sel_w = decode(reg_if.index);

    // The centre tap needs a wider word; the others are 16-bit registers.
    for (genvar t = 0; t < NTAP; t++)
    begin : g_tap
        localparam int RW = (t == `FEQ_CENTER_TAP) ? `FEQ_CENTER_REG_W : `FEQ_OUTER_REG_W;
        localparam int FW = (t == `FEQ_CENTER_TAP) ? `FEQ_CENTER_FIELD_W : `FEQ_OUTER_FIELD_W;
        logic [RW-1:0] q;

        feq_coef_reg
        #(
            .REG_W   (RW),
            .FIELD_W (FW)
        )
        u_reg
        (
            .clk_i   (clk_i),
            .nrst_i  (nrst_i),
            .we_i    (reg_if.wr_stb && sel_w[t]),
            .strb_i  (reg_if.wr_strb),
            .wdata_i (reg_if.wr_data),
            .value_o (q),
            .rd_o    (rd_w[t])
        );

        assign value_w[t] = 32'(q);
    end

    // Read multiplexer; an unmapped index reads as zero and reports no hit.
    always_comb
    begin
        rd_mux = `FEQ_RESET_VAL;
        for (int t = 0; t < NTAP; t++)
        begin
            if (sel_w[t])
                rd_mux = rd_w[t];
        end
    end

    assign reg_if.rd_data = rd_mux;
    assign reg_if.hit     = |sel_w;

    // The filter takes the full written field, MSB included.
    assign chan_b_tap0_value_o   = value_w[0][`FEQ_OUTER_FIELD_W-1:0];
    assign chan_b_tap1_value_o   = value_w[1][`FEQ_OUTER_FIELD_W-1:0];
    assign chan_b_tap2_value_o   = value_w[2][`FEQ_OUTER_FIELD_W-1:0];
    assign chan_b_tap3_value_o   = value_w[3][`FEQ_OUTER_FIELD_W-1:0];  // see R1
    assign chan_b_center_value_o = value_w[4][`FEQ_CENTER_FIELD_W-1:0]; // see R2
    assign chan_b_tap5_value_o   = value_w[5][`FEQ_OUTER_FIELD_W-1:0];  // see R3
    assign chan_b_tap6_value_o   = value_w[6][`FEQ_OUTER_FIELD_W-1:0];  // see R4
    assign chan_b_tap7_value_o   = value_w[7][`FEQ_OUTER_FIELD_W-1:0];  // see R5
    assign chan_b_tap8_value_o   = value_w[8][`FEQ_OUTER_FIELD_W-1:0];  // see R6

endmodule : feq_coef_bank

// >>> tb/feq_coef_bank_checker.sv
// Purpose: Port-level checks of the channel B coefficient bank.
// Assumes: One clock; pready comes in the first access cycle.
// Notes:   Tied to every bank instance by the bind at the foot.
module feq_coef_bank_checker
#(
    parameter int ADDR_W = 16
)
(
    // Clock, reset and APB.
    input wire logic                      clk_i,
    input wire logic                      nrst_i,
    input wire logic                      psel_i,
    input wire logic                      penable_i,
    input wire logic                      pwrite_i,
    input wire logic [ADDR_W-1:0]         paddr_i,
    input wire feq_pkg::feq_word_t        pwdata_i,
    input wire feq_pkg::feq_strb_t        pstrb_i,
    input wire logic                      pready_o,
    input wire feq_pkg::feq_word_t        prdata_o,
    input wire logic                      pslverr_o,
    // Coefficients.
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap0_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap1_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap2_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap3_value_o,
    input wire feq_pkg::feq_center_coef_t chan_b_center_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap5_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap6_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap7_value_o,
    input wire feq_pkg::feq_outer_coef_t  chan_b_tap8_value_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Full-word write taken at this edge; partial strobes are left to the bench.
    wire wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i == 4'hF;

    // Each write must reach its tap at the taking edge, MSB kept.
    property p_tap0; wr && paddr_i == 16'h1120 |=> chan_b_tap0_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap0: assert property (p_tap0) else $error("tap0 value wrong");
    property p_tap1; wr && paddr_i == 16'h1128 |=> chan_b_tap1_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap1: assert property (p_tap1) else $error("tap1 value wrong");
    property p_tap2; wr && paddr_i == 16'h1130 |=> chan_b_tap2_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap2: assert property (p_tap2) else $error("tap2 value wrong");
    property p_tap3; wr && paddr_i == 16'h1138 |=> chan_b_tap3_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap3: assert property (p_tap3) else $error("tap3 value wrong");
    property p_ctr; wr && paddr_i == 16'h1140 |=> chan_b_center_value_o == $past(pwdata_i[17:0]); endproperty
    a_ctr: assert property (p_ctr) else $error("centre value wrong");
    property p_tap5; wr && paddr_i == 16'h114C |=> chan_b_tap5_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap5: assert property (p_tap5) else $error("tap5 value wrong");
    property p_tap6; wr && paddr_i == 16'h1154 |=> chan_b_tap6_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap6: assert property (p_tap6) else $error("tap6 value wrong");
    property p_tap7; wr && paddr_i == 16'h115C |=> chan_b_tap7_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap7: assert property (p_tap7) else $error("tap7 value wrong");
    property p_tap8; wr && paddr_i == 16'h1164 |=> chan_b_tap8_value_o == $past(pwdata_i[11:0]); endproperty
    a_tap8: assert property (p_tap8) else $error("tap8 value wrong");

    // Readback hides the field MSB, bit 17 on the centre tap and bit 11 elsewhere.
    property p_msb; psel_i && penable_i && pready_o && !pwrite_i && !pslverr_o
        |-> !prdata_o[paddr_i == 16'h1140 ? 17 : 11]; endproperty
    a_msb: assert property (p_msb) else $error("readback MSB not zero");

    // The fourth tap and the centre tap start at zero right after reset leaves.
    property p_rst; $rose(nrst_i) |-> chan_b_tap3_value_o == 0 && chan_b_center_value_o == 0; endproperty
    a_rst: assert property (p_rst) else $error("tap not zero after reset");

    c_wr: cover property (wr && paddr_i == 16'h1140);
    c_rd: cover property (psel_i && pready_o && !pwrite_i);
    c_err: cover property (pready_o && pslverr_o);
endmodule : feq_coef_bank_checker

bind feq_coef_bank feq_coef_bank_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

// >>> tb/feq_coef_bank_tb_top.sv
// Purpose: Self-checking bench for the channel B coefficient bank.
// Assumes: 50 ns clock; byte address is four times the register index.
// Notes:   The bench waits for pready rather than counting cycles.
module feq_coef_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
    logic [15:0] paddr_i;
    feq_pkg::feq_word_t pwdata_i, prdata_o, rd, pat;
    feq_pkg::feq_strb_t pstrb_i;
    feq_pkg::feq_outer_coef_t tq [9];
    feq_pkg::feq_center_coef_t tc;
    int err_count, checked;
    logic [15:0] addr_tab [9] = '{16'h1120, 16'h1128, 16'h1130, 16'h1138, 16'h1140,
                                  16'h114C, 16'h1154, 16'h115C, 16'h1164};

    feq_coef_bank #(.ADDR_W(16)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .chan_b_tap0_value_o(tq[0]), .chan_b_tap1_value_o(tq[1]), .chan_b_tap2_value_o(tq[2]),
        .chan_b_tap3_value_o(tq[3]), .chan_b_center_value_o(tc), .chan_b_tap5_value_o(tq[5]),
        .chan_b_tap6_value_o(tq[6]), .chan_b_tap7_value_o(tq[7]), .chan_b_tap8_value_o(tq[8]));

    // Free-running clock.
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; data and status are taken at the rising edge that samples pready high.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Values read here are those sampled at this edge; only the watchdog ends an endless wait.
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : xfer

    // Every register and tap must read as zero.
    task automatic check_zero;
        for (int i = 0; i < 9; i++)
        begin
            xfer(1'b0, addr_tab[i], 32'h0, 4'h0);
            check("reset readback", 32'h0, rd);
            check("reset tap", 32'h0, i == 4 ? {14'h0, tc} : {20'h0, tq[i]});
        end
        $display("test reset values done");
    endtask : check_zero

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    // Watchdog: the tests need about 9.5 us.
    initial
    begin
        #100_000;
        err_count++;
        give_verdict();
    end

    initial
    begin
        {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        check_zero();
        // All ones sets every MSB; the second pattern keeps them clear.
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 9; i++)
            begin
                pat = p ? 32'h0000_A5A5 : 32'hFFFF_FFFF;
                xfer(1'b1, addr_tab[i], pat, 4'hF);
                xfer(1'b0, addr_tab[i], 32'h0, 4'h0);
                check("readback", pat & (i == 4 ? 32'h00FD_FFFF : 32'h0000_F7FF), rd);
                check("tap", pat & (i == 4 ? 32'h0003_FFFF : 32'h0000_0FFF),
                      i == 4 ? {14'h0, tc} : {20'h0, tq[i]});
            end
        $display("test write and readback done");
        // One byte lane only, then a lane beyond the 16-bit register.
        xfer(1'b1, 16'h1138, 32'h0, 4'hF);
        xfer(1'b1, 16'h1138, 32'hFFFF_FFFF, 4'h1);
        xfer(1'b1, 16'h1138, 32'hFFFF_FFFF, 4'h4);
        xfer(1'b0, 16'h1138, 32'h0, 4'h0);
        check("strobe readback", 32'h0000_00FF, rd);
        check("strobe tap", 32'h0000_00FF, {20'h0, tq[3]});
        $display("test byte strobes done");
        // Unmapped index and misaligned address are refused.
        xfer(1'b1, 16'h1124, 32'hFFFF_FFFF, 4'hF);
        check("unmapped error", 32'h1, {31'h0, er});
        xfer(1'b0, 16'h1139, 32'h0, 4'h0);
        check("misaligned error", 32'h1, {31'h0, er});
        check("misaligned data", 32'h0, rd);
        // An address above the decode width must not alias onto the first tap.
        xfer(1'b1, 16'h5120, 32'hFFFF_FFFF, 4'hF);
        check("alias error", 32'h1, {31'h0, er});
        check("alias tap", 32'h0000_05A5, {20'h0, tq[0]});
        $display("test refused access done");
        // Reset in mid-run clears what was written.
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        check_zero();
        give_verdict();
    end
endmodule : feq_coef_bank_tb_top
